// ### core/current_temp_fault_limits.sv
// Current and temperature fault limits with the over-temperature response sequencer.
`timescale 1ns/1ps
// Behaviour
// - Either phase peak above limit raises overcurrent.
// - Only post-blanking samples are compared.
// - Fault after configured consecutive exceeding periods.
// - Peak overcurrent shares averaged overcurrent status.
// - Either phase valley below limit raises undercurrent.
// - Valley undercurrent shares averaged undercurrent status.
// - Limits are Linear-11: mantissa times two^exponent.
// - Peak overcurrent limit resets to 30 A.
// - Valley undercurrent limit resets to -15 A.
// - External mode: either external sensor trips.
// - Overtemp sets status bits, source flag, alert.
// - Overtemp limit resets 125 C, range 0-175.
// - Mode 10 means disable then retry.
// - Alert low, fault bit cleared only by clear.
// - Retry 000 keeps output off until clear.
// - Retry 111 restarts until off or shutdown.
// - Fixed 210 ms between restart attempts.
// - Action byte resets to shutdown, no retry.
module current_temp_fault_limits #(
  parameter int CNT_W = 4,
  parameter int RETRY_CYCLES = fault_limits_pkg::RETRY_DELAY_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire fault_limits_pkg::cmd_req_t cmd,
  input wire logic clear_faults,
  output logic [15:0] rd_data,
  output logic cmd_refused,
  input wire fault_limits_pkg::current_sample_t cur,
  input wire logic period_end,
  input wire logic [CNT_W-1:0] current_sense_setup,
  input wire logic averaged_oc_fault,
  input wire logic averaged_uc_fault,
  input wire fault_limits_pkg::temp_sample_t temp,
  input wire logic external_sensor_select,
  input wire logic run_request,
  input wire logic bias_ok,
  input wire logic other_fault_shutdown,
  output fault_limits_pkg::fault_status_t status,
  output logic oc_fault_event,
  output logic uc_fault_event,
  output logic output_enable,
  output logic alert_output,
  output logic alert_oe_n
);

  function automatic logic signed [47:0] lin_to_fix(input logic [15:0] v);
    logic signed [47:0] m;
    logic signed [5:0] e;
    logic [5:0] sh;
    m = {{37{v[fault_limits_pkg::LIN_MANT_MSB]}}, v[fault_limits_pkg::LIN_MANT_MSB:0]};
    e = {v[fault_limits_pkg::LIN_EXP_MSB], v[fault_limits_pkg::LIN_EXP_MSB:fault_limits_pkg::LIN_EXP_LSB]};
    sh = 6'(e + 6'sd16);
    return m <<< sh;
  endfunction

  localparam logic signed [47:0] OT_MIN_FIX = 48'(fault_limits_pkg::OT_LIMIT_MIN_C) <<< fault_limits_pkg::FIX_FRAC;
  localparam logic signed [47:0] OT_MAX_FIX = 48'(fault_limits_pkg::OT_LIMIT_MAX_C) <<< fault_limits_pkg::FIX_FRAC;

  logic [15:0] oc_limit_reg;
  logic [15:0] uc_limit_reg;
  logic [15:0] ot_limit_reg;
  logic [7:0] ot_action_reg;
  logic wr_en;
  logic ot_limit_ok;
  logic code_known;

  // Decode of the command strobe; a limit outside its permitted range is refused rather than stored.
  assign wr_en = cmd.valid & cmd.write;
  assign ot_limit_ok = (lin_to_fix(cmd.wdata) >= OT_MIN_FIX) && (lin_to_fix(cmd.wdata) <= OT_MAX_FIX);
  assign code_known = (cmd.code == fault_limits_pkg::CMD_PEAK_OC_LIMIT) ||
                      (cmd.code == fault_limits_pkg::CMD_VALLEY_UC_LIMIT) ||
                      (cmd.code == fault_limits_pkg::CMD_OT_LIMIT) ||
                      (cmd.code == fault_limits_pkg::CMD_OT_ACTION);

  // Limit register writes; an out-of-range temperature limit is not stored.
  always_ff @(posedge clk) begin
    if (srst) begin
      oc_limit_reg <= fault_limits_pkg::PEAK_OC_LIMIT_RST;
      uc_limit_reg <= fault_limits_pkg::VALLEY_UC_LIMIT_RST;
      ot_limit_reg <= fault_limits_pkg::OT_LIMIT_RST;
      ot_action_reg <= fault_limits_pkg::OT_ACTION_RST;
    end else if (ce && wr_en) begin
      if (cmd.code == fault_limits_pkg::CMD_PEAK_OC_LIMIT) begin
        oc_limit_reg <= cmd.wdata;
      end else if (cmd.code == fault_limits_pkg::CMD_VALLEY_UC_LIMIT) begin
        uc_limit_reg <= cmd.wdata;
      end else if (cmd.code == fault_limits_pkg::CMD_OT_LIMIT) begin
        if (ot_limit_ok) begin
          ot_limit_reg <= cmd.wdata;
        end
      end else if (cmd.code == fault_limits_pkg::CMD_OT_ACTION) begin
        ot_action_reg <= cmd.wdata[7:0];
      end
    end
  end

  // Read data and refusal flag, one cycle after the command.
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= 16'h0000;
      cmd_refused <= 1'b0;
    end else if (ce) begin
      cmd_refused <= cmd.valid & (~code_known |
                     (wr_en & (cmd.code == fault_limits_pkg::CMD_OT_LIMIT) & ~ot_limit_ok));
      if (cmd.valid && !cmd.write) begin
        if (cmd.code == fault_limits_pkg::CMD_PEAK_OC_LIMIT) begin
          rd_data <= oc_limit_reg;
        end else if (cmd.code == fault_limits_pkg::CMD_VALLEY_UC_LIMIT) begin
          rd_data <= uc_limit_reg;
        end else if (cmd.code == fault_limits_pkg::CMD_OT_LIMIT) begin
          rd_data <= ot_limit_reg;
        end else if (cmd.code == fault_limits_pkg::CMD_OT_ACTION) begin
          rd_data <= {8'h00, ot_action_reg};
        end else begin
          // Unknown codes read as zero, so a probing host sees a defined value.
          rd_data <= 16'h0000;
        end
      end
    end
  end

  // Per-phase qualification of peak and valley current.
  logic [1:0] oc_phase_fault;
  logic [1:0] uc_phase_fault;
  logic post_blank_valid;

  assign post_blank_valid = cur.valid & cur.post_blank;

  for (genvar p = 0; p < 2; p++) begin : g_phase
    // Each phase has its own counters, so a quiet phase cannot mask a faulty one.
    logic oc_over;
    logic uc_over;
    assign oc_over = lin_to_fix(cur.peak[p]) > lin_to_fix(oc_limit_reg);
    assign uc_over = lin_to_fix(cur.valley[p]) < lin_to_fix(uc_limit_reg);

    period_fault_qualifier #(.CNT_W(CNT_W)) u_oc_qual (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .sample_valid(post_blank_valid),
      .over(oc_over),
      .period_end(period_end),
      .need(current_sense_setup),
      .fault_pulse(oc_phase_fault[p])
    );

    period_fault_qualifier #(.CNT_W(CNT_W)) u_uc_qual (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .sample_valid(post_blank_valid),
      .over(uc_over),
      .period_end(period_end),
      .need(current_sense_setup),
      .fault_pulse(uc_phase_fault[p])
    );
  end

  assign oc_fault_event = (|oc_phase_fault) | averaged_oc_fault;
  assign uc_fault_event = (|uc_phase_fault) | averaged_uc_fault;

  // Temperature comparison against the active sensors.
  logic int_over;
  logic ext0_over;
  logic ext1_over;
  logic ot_over;

  assign int_over = temp.valid & ~external_sensor_select & (lin_to_fix(temp.internal) > lin_to_fix(ot_limit_reg));
  assign ext0_over = temp.valid & external_sensor_select & (lin_to_fix(temp.ext0) > lin_to_fix(ot_limit_reg));
  assign ext1_over = temp.valid & external_sensor_select & (lin_to_fix(temp.ext1) > lin_to_fix(ot_limit_reg));
  assign ot_over = int_over | ext0_over | ext1_over;

  // Sticky status bits; a new fault in the clearing cycle wins.
  always_ff @(posedge clk) begin
    if (srst) begin
      status <= '0;
    end else if (ce) begin
      if (clear_faults) begin
        status <= '0;
      end
      if (ot_over) begin
        status.temperature <= 1'b1;
        status.ot_warning <= 1'b1;
      end
      if (int_over) begin
        status.fault_int <= 1'b1;
      end
      if (ext0_over) begin
        status.ext_sensor0_fault_flag <= 1'b1;
      end
      if (ext1_over) begin
        status.ext_sensor1_fault_flag <= 1'b1;
      end
      if (oc_fault_event) begin
        status.oc_fault <= 1'b1;
      end
      if (uc_fault_event) begin
        status.uc_fault <= 1'b1;
      end
    end
  end

  // The pin is open drain: it is only ever pulled low, never driven high.
  // alert pulled low on fault
  assign alert_output = 1'b0;
  assign alert_oe_n = ~(|status);

  // Over-temperature response sequencer.
  fault_limits_pkg::ot_state_t ot_state_reg;
  logic [31:0] retry_cnt_reg;
  logic [1:0] act_mode;
  logic [2:0] act_retry;
  logic stop_retry;
  logic ot_trip;
  fault_limits_pkg::ot_state_t trip_state;

  // Action fields, and the conditions that end continuous retry.
  assign act_mode = ot_action_reg[fault_limits_pkg::ACT_MODE_MSB:fault_limits_pkg::ACT_MODE_LSB];
  assign act_retry = ot_action_reg[fault_limits_pkg::ACT_RETRY_MSB:fault_limits_pkg::ACT_RETRY_LSB];
  assign stop_retry = ~run_request | ~bias_ok | other_fault_shutdown;

  assign ot_trip = ot_over && (act_mode == fault_limits_pkg::ACT_MODE_DISABLE_RETRY);
  assign trip_state = (act_retry == fault_limits_pkg::ACT_RETRY_FOREVER && !stop_retry) ?
                      fault_limits_pkg::OT_RETRY_WAIT : fault_limits_pkg::OT_HOLD;

  always_ff @(posedge clk) begin
    if (srst) begin
      ot_state_reg <= fault_limits_pkg::OT_RUN;
      retry_cnt_reg <= 32'h0000_0000;
    end else if (ce) begin
      case (ot_state_reg)
        fault_limits_pkg::OT_RUN: begin
          if (ot_trip) begin
            // The delay counter restarts on every trip so each attempt waits the full time.
            retry_cnt_reg <= 32'h0000_0000;
            ot_state_reg <= trip_state;
          end
        end
        fault_limits_pkg::OT_RETRY_WAIT: begin
          // off, bias loss, shutdown end retry
          if (stop_retry) begin
            ot_state_reg <= fault_limits_pkg::OT_HOLD;
          end else if (retry_cnt_reg >= 32'(RETRY_CYCLES - 1)) begin
            ot_state_reg <= fault_limits_pkg::OT_RUN;
            retry_cnt_reg <= 32'h0000_0000;
          end else begin
            retry_cnt_reg <= retry_cnt_reg + 32'h0000_0001;
          end
        end
        fault_limits_pkg::OT_HOLD: begin
          if (clear_faults) begin
            // A fresh trip in the clearing cycle wins, so the clear cannot re-enable a hot stage.
            if (ot_trip) begin
              ot_state_reg <= trip_state;
              retry_cnt_reg <= 32'h0000_0000;
            end else begin
              ot_state_reg <= fault_limits_pkg::OT_RUN;
            end
          end
        end
        default: begin
          ot_state_reg <= fault_limits_pkg::OT_HOLD;
        end
      endcase
    end
  end

  // Output enable follows the run request while no over-temperature shutdown holds.
  always_ff @(posedge clk) begin
    if (srst) begin
      output_enable <= 1'b0;
    end else if (ce) begin
      output_enable <= run_request & (ot_state_reg == fault_limits_pkg::OT_RUN);
    end
  end

endmodule

// ### core/fault_limits_pkg.sv
// Shared constants and carrier types for the current and temperature fault limit block.
package fault_limits_pkg;

  // Command codes of the limit registers.
  localparam logic [7:0] CMD_PEAK_OC_LIMIT = 8'h46;
  localparam logic [7:0] CMD_VALLEY_UC_LIMIT = 8'h4b;
  localparam logic [7:0] CMD_OT_LIMIT = 8'h4f;
  localparam logic [7:0] CMD_OT_ACTION = 8'h50;

  // Power-on values of the limit registers.
  localparam logic [15:0] PEAK_OC_LIMIT_RST = 16'hdbc0;
  localparam logic [15:0] VALLEY_UC_LIMIT_RST = 16'hd440;
  localparam logic [15:0] OT_LIMIT_RST = 16'hebe8;
  localparam logic [7:0] OT_ACTION_RST = 8'h80;

  // Linear-11 field positions.
  localparam int LIN_EXP_MSB = 15;
  localparam int LIN_EXP_LSB = 11;
  localparam int LIN_MANT_MSB = 10;

  // Fixed-point form used for comparisons: fraction bits.
  localparam int FIX_FRAC = 16;

  // Over-temperature action byte fields.
  localparam int ACT_MODE_MSB = 7;
  localparam int ACT_MODE_LSB = 6;
  localparam int ACT_RETRY_MSB = 5;
  localparam int ACT_RETRY_LSB = 3;
  localparam logic [1:0] ACT_MODE_DISABLE_RETRY = 2'h2;
  localparam logic [2:0] ACT_RETRY_NONE = 3'h0;
  localparam logic [2:0] ACT_RETRY_FOREVER = 3'h7;

  // Permitted range of the over-temperature limit, in degrees Celsius.
  localparam int OT_LIMIT_MIN_C = 0;
  localparam int OT_LIMIT_MAX_C = 175;

  // Restart delay and its cycle count at the core clock.
  localparam int RETRY_DELAY_MS = 210;
  localparam int CLK_KHZ = 200000;
  localparam int RETRY_DELAY_CYCLES = RETRY_DELAY_MS * CLK_KHZ;

  // One command from the management bus.
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } cmd_req_t;

  // One set of per-phase current samples, Linear-11 amperes.
  typedef struct packed {
    logic valid;
    logic post_blank;
    logic [1:0][15:0] peak;
    logic [1:0][15:0] valley;
  } current_sample_t;

  // One set of temperature readings, Linear-11 degrees Celsius.
  typedef struct packed {
    logic valid;
    logic [15:0] internal;
    logic [15:0] ext0;
    logic [15:0] ext1;
  } temp_sample_t;

  // Sticky status bits.
  typedef struct packed {
    logic temperature;
    logic ot_warning;
    logic fault_int;
    logic ext_sensor0_fault_flag;
    logic ext_sensor1_fault_flag;
    logic oc_fault;
    logic uc_fault;
  } fault_status_t;

  // Over-temperature response states.
  typedef enum logic [1:0] {
    OT_RUN = 2'b00,
    OT_HOLD = 2'b01,
    OT_RETRY_WAIT = 2'b10
  } ot_state_t;

endpackage

// ### core/period_fault_qualifier.sv
// Counts consecutive switching periods in which a current limit is exceeded.
`timescale 1ns/1ps
module period_fault_qualifier #(
  parameter int CNT_W = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic sample_valid,
  input wire logic over,
  input wire logic period_end,
  input wire logic [CNT_W-1:0] need,
  output logic fault_pulse
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic miss_reg;
  logic seen_reg;
  logic miss_now;
  logic seen_now;
  logic [CNT_W-1:0] need_eff;

  // A period counts only if it saw a sample and none of them was in range.
  assign miss_now = miss_reg | (sample_valid & ~over);
  assign seen_now = seen_reg | sample_valid;
  assign cnt_next = (&cnt_reg) ? cnt_reg : cnt_reg + 1'b1;
  assign need_eff = (need == '0) ? {{(CNT_W-1){1'b0}}, 1'b1} : need;

  // Period tracking and counting.
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= '0;
      miss_reg <= 1'b0;
      seen_reg <= 1'b0;
      fault_pulse <= 1'b0;
    end else if (ce) begin
      fault_pulse <= 1'b0;
      if (period_end) begin
        miss_reg <= 1'b0;
        seen_reg <= 1'b0;
        if (seen_now && !miss_now) begin
          cnt_reg <= cnt_next;
          fault_pulse <= (cnt_next >= need_eff);
        end else if (miss_now) begin
          cnt_reg <= '0;
        end
      end else begin
        miss_reg <= miss_now;
        seen_reg <= seen_now;
        if (sample_valid && !over) begin
          cnt_reg <= '0;
        end
      end
    end
  end

endmodule

// ### tb/fault_limits_sva.sv
// Port checker for the current and temperature fault limit block.
`timescale 1ns/1ps
module fault_limits_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic clear_faults,
  input wire logic period_end,
  input wire logic averaged_oc_fault,
  input wire logic run_request,
  input wire fault_limits_pkg::temp_sample_t temp,
  input wire fault_limits_pkg::fault_status_t status,
  input wire logic oc_fault_event,
  input wire logic uc_fault_event,
  input wire logic output_enable,
  input wire logic alert_output,
  input wire logic alert_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // The alert pin is pulled low exactly while a status bit is set.
  alert_tracks_a: assert property (alert_oe_n == !(|status))
    else $error("alert enable wrong");
  alert_level_a: assert property (alert_output == 1'b0)
    else $error("alert data level wrong");
  // Current fault events land in the shared status bits.
  oc_status_a: assert property (ce && oc_fault_event |=> status.oc_fault)
    else $error("oc status missed");
  uc_status_a: assert property (ce && uc_fault_event |=> status.uc_fault)
    else $error("uc status missed");
  oc_period_a: assert property (oc_fault_event && !averaged_oc_fault |-> $past(period_end))
    else $error("oc event away from period end");
  // The oc status bit holds until cleared; all bits clear together.
  oc_sticky_a: assert property (ce && !clear_faults && status.oc_fault |=> status.oc_fault)
    else $error("oc status dropped");
  clear_all_a: assert property (ce && clear_faults && !temp.valid && !oc_fault_event && !uc_fault_event
    |=> status == '0)
    else $error("clear left status");
  // Over-temperature flags come from a reading and set the source flag.
  ot_cause_a: assert property ($rose(status.temperature) |-> $past(ce) && $past(temp.valid))
    else $error("temperature bit without reading");
  ot_flags_a: assert property ($rose(status.temperature) |-> status.ot_warning && |status[4:2])
    else $error("temperature flags incomplete");
  oe_cause_a: assert property ($rose(output_enable) |-> $past(run_request))
    else $error("output on without run request");
  oc_seen_c: cover property (oc_fault_event && !averaged_oc_fault);
  ot_seen_c: cover property ($rose(status.temperature));
  retry_seen_c: cover property ($fell(output_enable) ##[1:40] $rose(output_enable));
endmodule

// ### tb/host_model.sv
// Management bus host that issues register commands and fault clears.
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output fault_limits_pkg::cmd_req_t cmd,
  output logic clear_faults
);
  logic risky = 1'b0;
  initial begin
    cmd = '0;
    clear_faults = 1'b0;
  end
  // One command every two cycles; idle fields show garbage so nothing rides on stale data.
  task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d);
    if (w && c == 8'h50 && d[7:3] == 5'h17 && !risky) return;
    @(negedge clk);
    cmd <= '{1'b1, w, c, d};
    @(negedge clk);
    cmd <= '{1'b0, ~w, ~c, ~d};
  endtask
  // Clear-faults command as a one-cycle pulse.
  task automatic clear();
    @(negedge clk);
    clear_faults <= 1'b1;
    @(negedge clk);
    clear_faults <= 1'b0;
  endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the current and temperature fault limit block.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, a); end end
module tb;
  localparam int RC = 20;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic period_end = 1'b0;
  logic [3:0] setup = 4'h2;
  logic avg_oc = 1'b0;
  logic avg_uc = 1'b0;
  logic ext_sel = 1'b1;
  logic run = 1'b1;
  logic bias = 1'b1;
  logic other = 1'b0;
  logic rd_pend = 1'b0;
  fault_limits_pkg::current_sample_t cur = '0;
  fault_limits_pkg::temp_sample_t temp = '0;
  fault_limits_pkg::cmd_req_t cmd;
  fault_limits_pkg::fault_status_t status;
  logic clear_faults, cmd_refused, oc_ev, uc_ev, oe, alert, alert_oe_n;
  logic [15:0] rd_data;
  logic [15:0] v;
  logic [17:0] e;
  logic [17:0] exp_q[$];
  logic [7:0] modes[3] = '{8'h00, 8'h40, 8'hc0};
  logic [31:0] seed = 32'h00000049;
  int error_cnt = 0;
  int checks_done = 0;
  int oc_n = 0;
  int uc_n = 0;
  int n = 0;
  // Free-running clock.
  initial begin
    forever #2.5 clk = ~clk;
  end
  host_model u_host (.clk(clk), .cmd(cmd), .clear_faults(clear_faults));
  current_temp_fault_limits #(.CNT_W(4), .RETRY_CYCLES(RC)) u_dut (.clk(clk), .srst(srst), .ce(ce), .cmd(cmd),
    .clear_faults(clear_faults), .rd_data(rd_data), .cmd_refused(cmd_refused), .cur(cur), .period_end(period_end),
    .current_sense_setup(setup), .averaged_oc_fault(avg_oc), .averaged_uc_fault(avg_uc), .temp(temp),
    .external_sensor_select(ext_sel), .run_request(run), .bias_ok(bias), .other_fault_shutdown(other),
    .status(status), .oc_fault_event(oc_ev), .uc_fault_event(uc_ev), .output_enable(oe), .alert_output(alert),
    .alert_oe_n(alert_oe_n));
  // Mark each taken command so its answer is checked a cycle later.
  always @(posedge clk) rd_pend <= !srst && ce && cmd.valid;
  // Count event pulses and compare each answer with the oldest note.
  always @(negedge clk) begin
    if (oc_ev === 1'b1) oc_n++;
    if (uc_ev === 1'b1) uc_n++;
    if (rd_pend === 1'b1) begin
      e = 18'h3ffff;
      if (exp_q.size() > 0) e = exp_q.pop_front();
      if (e[17]) `CHK("rd_data", e[15:0], rd_data)
      `CHK("cmd_refused", e[16], cmd_refused)
    end
  end
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic bad);
    exp_q.push_back({1'b0, bad, 16'h0000});
    u_host.send(1'b1, c, d);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] d, input logic bad);
    exp_q.push_back({1'b1, bad, d});
    u_host.send(1'b0, c, rnd());
  endtask
  // One switching period: phase one peak and phase zero valley.
  task automatic per(input logic s, input logic pb, input logic [15:0] pk, input logic [15:0] vl);
    @(negedge clk);
    cur <= '{s, pb, {pk, 16'h0000}, {16'h0000, vl}};
    period_end <= 1'b1;
    @(negedge clk);
    cur <= '0;
    period_end <= 1'b0;
  endtask
  task automatic heat(input logic [15:0] ti, input logic [15:0] t1);
    @(negedge clk);
    temp <= '{1'b1, ti, 16'h0832, t1};
    @(negedge clk);
    temp <= '0;
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wait_oe(input logic w);
    n = 0;
    while (oe !== w && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (oe !== w) begin
      error_cnt++;
      conclude();
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    idle(3);
    srst <= 1'b0;
    // power-on values, then an unknown code.
    rd(8'h46, 16'hdbc0, 1'b0);
    rd(8'h4b, 16'hd440, 1'b0);
    rd(8'h4f, 16'hebe8, 1'b0);
    rd(8'h50, 16'h0080, 1'b0);
    rd(8'h47, 16'h0000, 1'b1);
    wr(8'h47, rnd(), 1'b1);
    $display("reset values done");
    // random words and bytes read back, limit range enforced.
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      wr(8'h4b, v, 1'b0);
      rd(8'h4b, v, 1'b0);
      wr(8'h50, v & 16'hff7f, 1'b0);
      rd(8'h50, {8'h00, v[7:0] & 8'h7f}, 1'b0);
    end
    wr(8'h4b, 16'hd440, 1'b0);
    wr(8'h50, 16'h0080, 1'b0);
    wr(8'h4f, 16'h00b0, 1'b1);
    wr(8'h4f, 16'h0832, 1'b0);
    rd(8'h4f, 16'h0832, 1'b0);
    idle(2);
    $display("register access done");
    // Peak over limit on one phase, broken runs, blanked and empty periods.
    per(1'b1, 1'b1, 16'h001f, 16'h0000);
    per(1'b1, 1'b1, 16'h0000, 16'h0000);
    per(1'b1, 1'b1, 16'h001f, 16'h0000);
    per(1'b1, 1'b0, 16'h001f, 16'h0000);
    per(1'b0, 1'b1, 16'h001f, 16'h0000);
    idle(2);
    `CHK("oc early", 0, oc_n)
    per(1'b1, 1'b1, 16'h001f, 16'h0000);
    idle(3);
    `CHK("oc count", 1, oc_n)
    `CHK("oc status", 1'b1, status.oc_fault)
    `CHK("alert", 1'b0, alert_oe_n)
    // Valley under limit on the other phase.
    per(1'b1, 1'b1, 16'h0000, 16'h07f0);
    per(1'b1, 1'b1, 16'h0000, 16'h07f0);
    idle(3);
    `CHK("uc count", 1, uc_n)
    `CHK("uc status", 1'b1, status.uc_fault)
    avg_oc <= 1'b1;
    avg_uc <= 1'b1;
    idle(1);
    avg_oc <= 1'b0;
    avg_uc <= 1'b0;
    idle(2);
    `CHK("shared oc", 2, oc_n)
    `CHK("shared uc", 2, uc_n)
    u_host.clear();
    idle(2);
    `CHK("cleared", 7'h00, status)
    $display("current faults done");
    // Equal reading is no fault; external sensor one over shuts down.
    heat(16'h0000, 16'h0832);
    idle(3);
    `CHK("equal temp", 7'h00, status)
    heat(16'h0000, 16'h0833);
    wait_oe(1'b0);
    `CHK("ext status", 7'h64, status)
    idle(RC + 10);
    `CHK("held off", 1'b0, oe)
    u_host.clear();
    wait_oe(1'b1);
    $display("shutdown done");
    // Unused modes only flag the fault.
    ext_sel <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      wr(8'h50, {8'h00, modes[i]}, 1'b0);
      heat(16'h0833, 16'h0000);
      idle(3);
      `CHK("int status", 7'h70, status)
      `CHK("no shutdown", 1'b1, oe)
      u_host.clear();
    end
    // Continuous retry with the fixed delay, then stopped by another fault.
    u_host.risky = 1'b1;
    wr(8'h50, 16'h00b8, 1'b0);
    heat(16'h0833, 16'h0000);
    wait_oe(1'b0);
    wait_oe(1'b1);
    `CHK("retry gap", RC, n)
    heat(16'h0833, 16'h0000);
    wait_oe(1'b0);
    // A frozen clock enable holds the retry delay, so the stage stays off past it.
    ce <= 1'b0;
    idle(RC + 10);
    `CHK("frozen retry", 1'b0, oe)
    ce <= 1'b1;
    other <= 1'b1;
    idle(RC + 10);
    `CHK("retry stopped", 1'b0, oe)
    other <= 1'b0;
    u_host.clear();
    wait_oe(1'b1);
    // Loss of bias also ends continuous retry.
    heat(16'h0833, 16'h0000);
    wait_oe(1'b0);
    bias <= 1'b0;
    idle(RC + 10);
    `CHK("bias stopped", 1'b0, oe)
    bias <= 1'b1;
    u_host.clear();
    wait_oe(1'b1);
    run <= 1'b0;
    wait_oe(1'b0);
    $display("retry done");
    conclude();
  end
endmodule
bind current_temp_fault_limits fault_limits_sva u_sva (.clk(clk), .srst(srst), .ce(ce), .clear_faults(clear_faults),
  .period_end(period_end), .averaged_oc_fault(averaged_oc_fault), .run_request(run_request), .temp(temp),
  .status(status), .oc_fault_event(oc_fault_event), .uc_fault_event(uc_fault_event),
  .output_enable(output_enable), .alert_output(alert_output), .alert_oe_n(alert_oe_n));
